// *** include/sdc_pkg.sv ***
// Package for the SDRAM command and timing core: encodings, widths, latencies.
// Assumes a single 100 MHz clock domain and a synchronous active-low reset.
package sdc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int BANKS = 4;
  localparam int ROWS = 4096;
  localparam int DQ_W = 8;
  localparam int COL_W = 10;
  localparam int COLS = 1024;
  localparam int MEM_WORDS = 16;
  localparam int MEM_AW = 4;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int MASK_READ_LAT = 2;
  localparam int CKE_LAT = 1;
  localparam int MODE_LOAD_RECOVERY = 2;
  localparam int WR_PRE_GAP = 2;
  localparam int WR_ACT_GAP = 5;
  localparam int MAX_CL = 3;
  localparam logic [1:0] CL_RESET = 2'h2;
  localparam logic [2:0] BL_RESET = 3'h0;
  localparam int AP_BIT = 10;

  // ----------------------------------------------------------------
  // Commands (cs_n, ras_n, cas_n, we_n)
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP = 4'h7,
    CMD_ACTIVE = 4'h3,
    CMD_READ = 4'h5,
    CMD_WRITE = 4'h4,
    CMD_STOP = 4'h6,
    CMD_PRECHARGE = 4'h2,
    CMD_REFRESH = 4'h1,
    CMD_MODE_LOAD = 4'h0
  } sdc_cmd_t;

  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_enable_n;
  } sdc_cmd_pins_t;

  typedef struct packed {
    logic bank_select_bit1;
    logic bank_select_bit0;
    logic [ADDR_W-1:0] addr;
  } sdc_addr_t;

  typedef struct packed {
    logic valid;
    logic [DQ_W-1:0] data;
  } sdc_rd_word_t;

endpackage

// *** verilog/sdc_read_pipe.sv ***
// Read output pipeline: delays read words by CAS latency and applies byte mask.
// Assumes the caller supplies a one-cycle word, mask and a precharge kill.
`timescale 1ns/100ps
`default_nettype none
module sdc_read_pipe (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration
  input wire logic [1:0] cas_latency,
  // Word entering the pipe
  input wire sdc_pkg::sdc_rd_word_t word_in,
  input wire logic kill,
  input wire logic mask_in,
  // Pin side
  output logic [sdc_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe
);

  sdc_pkg::sdc_rd_word_t stage_reg [sdc_pkg::MAX_CL];
  sdc_pkg::sdc_rd_word_t stage_next [sdc_pkg::MAX_CL];
  logic [sdc_pkg::MASK_READ_LAT-1:0] mask_reg;
  logic [sdc_pkg::MASK_READ_LAT-1:0] mask_next;
  logic [sdc_pkg::DQ_W-1:0] dq_reg;
  logic [sdc_pkg::DQ_W-1:0] dq_next;
  logic oe_reg;
  logic oe_next;
  sdc_pkg::sdc_rd_word_t tap;

  // ----------------------------------------------------------------
  // Latency stages
  // ----------------------------------------------------------------
  always_comb begin
    stage_next[0] = word_in;
    for (int i = 1; i < sdc_pkg::MAX_CL; i++) begin
      stage_next[i] = stage_reg[i-1];
    end
    // Words already in flight drain, so the drive stops CL cycles after precharge [R12]
    if (kill) begin
      stage_next[0].valid = 1'b0;
    end
    mask_next = {mask_reg[sdc_pkg::MASK_READ_LAT-2:0], mask_in};
    tap = stage_reg[cas_latency - 2'h1];
    dq_next = tap.data;
    // Mask sampled two edges earlier turns the output off [R09]
    oe_next = tap.valid && !mask_reg[sdc_pkg::MASK_READ_LAT-1];
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < sdc_pkg::MAX_CL; i++) begin
        stage_reg[i] <= '0;
      end
      mask_reg <= '0;
      dq_reg <= '0;
      oe_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      mask_reg <= mask_next;
      dq_reg <= dq_next;
      oe_reg <= oe_next;
    end
  end

  assign dq_out = dq_reg;
  assign dq_oe = oe_reg;

endmodule // sdc_read_pipe
`default_nettype wire

// *** verilog/sdc_core.sv ***
// SDRAM command decode, bank state, burst engine and clock-enable timing.
// Assumes all pins are synchronous to mclk; the controller keeps its own gaps.
//
// Overview of operation
// R01: Controller leaves one cycle before burst stop
// R02: New column command accepted every cycle
// R03: Controller waits one cycle before next column
// R04: Clock-enable low stops clock one cycle later
// R05: Clock-enable high resumes one cycle later
// R06: Controller waits write-to-activate gap with autoprecharge
// R07: Controller waits two cycles before precharge
// R08: Write mask blocks same-cycle data
// R09: Read mask floats outputs two cycles later
// R10: First write word taken with command
// R11: Controller waits two cycles after mode load
// R12: Precharge floats read outputs after CAS latency
// R13: Controller waits after self refresh exit
// R14: Controller pauses then issues two refreshes
// R15: Controller repeats wake refreshes after lapse
// R16: Controller keeps clock steady during accesses
// R17: Controller allows autoprecharge write recovery time
// R18: All inputs sampled on rising clock edge
// R19: Four banks of 4096 rows, 1024 columns; storage keeps only four columns of each bank, row unused
// R20: Bursts of programmed length through opened row
// R21: Activate takes bank selects and row address
// R22: Column command takes starting column address
// R23: Refresh encoding; clock-enable low enters self refresh
// R24: Controller idles with no-operation commands
`timescale 1ns/100ps
`default_nettype none
module sdc_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Command pins
  input wire logic clock_enable,
  input wire sdc_pkg::sdc_cmd_pins_t cmd_pins,
  input wire sdc_pkg::sdc_addr_t addr_pins,
  input wire logic byte_mask,
  // Data pins
  input wire logic [sdc_pkg::DQ_W-1:0] dq_in,
  output logic [sdc_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe,
  // Status
  output logic self_refresh,
  output logic power_down,
  output logic [sdc_pkg::BANKS-1:0] bank_open
);

  typedef enum logic [1:0] {
    SDC_IDLE,
    SDC_READ,
    SDC_WRITE
  } sdc_burst_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Four banks of rows; storage keeps only four columns of each bank [R19]
  logic [sdc_pkg::DQ_W-1:0] mem [sdc_pkg::MEM_WORDS];
  logic cke_reg;
  logic cke_next;
  logic sref_reg;
  logic sref_next;
  logic [1:0] cl_reg;
  logic [1:0] cl_next;
  logic [2:0] bl_reg;
  logic [2:0] bl_next;
  logic [sdc_pkg::BANKS-1:0] open_reg;
  logic [sdc_pkg::BANKS-1:0] open_next;
  logic [sdc_pkg::ADDR_W-1:0] row_reg [sdc_pkg::BANKS];
  logic [sdc_pkg::ADDR_W-1:0] row_next [sdc_pkg::BANKS];
  sdc_burst_t burst_reg;
  sdc_burst_t burst_next;
  logic [1:0] bank_reg;
  logic [1:0] bank_next;
  logic [sdc_pkg::COL_W-1:0] col_reg;
  logic [sdc_pkg::COL_W-1:0] col_next;
  logic [8:0] left_reg;
  logic [8:0] left_next;
  logic ap_reg;
  logic ap_next;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Codes above 3 give a full page, cut at 511 beats
  function automatic logic [8:0] burst_len(input logic [2:0] code);
    case (code)
      3'h0: burst_len = 9'h001;
      3'h1: burst_len = 9'h002;
      3'h2: burst_len = 9'h004;
      3'h3: burst_len = 9'h008;
      default: burst_len = 9'h1FF;
    endcase
  endfunction

  // Columns alias every four words; the row plays no part in storage
  function automatic logic [sdc_pkg::MEM_AW-1:0] mem_index(
      input logic [1:0] bank, input logic [sdc_pkg::COL_W-1:0] col);
    mem_index = {bank, col[1:0]};
  endfunction

  sdc_pkg::sdc_cmd_t cmd;
  logic [1:0] bank_sel;
  logic cmd_live;
  logic col_cmd;
  logic stop_now;
  logic precharge_now;
  logic wr_beat;
  logic rd_beat;
  logic [sdc_pkg::MEM_AW-1:0] beat_idx;
  logic [sdc_pkg::COL_W-1:0] beat_col;
  logic [1:0] beat_bank;
  sdc_pkg::sdc_rd_word_t rd_word;

  always_comb begin
    // Every input is taken as registered on this rising edge [R18]
    cmd = sdc_pkg::sdc_cmd_t'(cmd_pins);
    bank_sel = {addr_pins.bank_select_bit1, addr_pins.bank_select_bit0}; // [R21]
    // Commands act only while the internal clock runs [R05]
    cmd_live = cke_reg && !sref_reg && !cmd_pins.chip_select_n;
    col_cmd = cmd_live && (cmd == sdc_pkg::CMD_READ || cmd == sdc_pkg::CMD_WRITE);
    stop_now = cmd_live && cmd == sdc_pkg::CMD_STOP;
    precharge_now = cmd_live && cmd == sdc_pkg::CMD_PRECHARGE;
  end

  // ----------------------------------------------------------------
  // Clock enable, self refresh, mode
  // ----------------------------------------------------------------
  always_comb begin
    // Pin level acts from the following cycle [R04] [R05]
    cke_next = clock_enable;
    sref_next = sref_reg;
    // Refresh encoding with enable low enters self refresh [R23]
    if (cke_reg && !clock_enable && !cmd_pins.chip_select_n && cmd == sdc_pkg::CMD_REFRESH) begin
      sref_next = 1'b1;
    end else if (sref_reg && clock_enable) begin
      sref_next = 1'b0;
    end
    cl_next = cl_reg;
    bl_next = bl_reg;
    if (cmd_live && cmd == sdc_pkg::CMD_MODE_LOAD) begin
      bl_next = addr_pins.addr[2:0];
      cl_next = (addr_pins.addr[5:4] == 2'h0) ? cl_reg : addr_pins.addr[5:4];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cke_reg <= 1'b0;
      sref_reg <= 1'b0;
      cl_reg <= sdc_pkg::CL_RESET;
      bl_reg <= sdc_pkg::BL_RESET;
    end else begin
      cke_reg <= cke_next;
      sref_reg <= sref_next;
      cl_reg <= cl_next;
      bl_reg <= bl_next;
    end
  end

  // ----------------------------------------------------------------
  // Bank rows
  // ----------------------------------------------------------------
  always_comb begin
    open_next = open_reg;
    row_next = row_reg;
    // Activate opens bank and latches its row [R20] [R21]
    if (cmd_live && cmd == sdc_pkg::CMD_ACTIVE) begin
      open_next[bank_sel] = 1'b1;
      row_next[bank_sel] = addr_pins.addr;
    end
    // Address bit 10 picks every bank, otherwise only the selected one
    if (precharge_now) begin
      if (addr_pins.addr[sdc_pkg::AP_BIT]) begin
        open_next = '0;
      end else begin
        open_next[bank_sel] = 1'b0;
      end
    end
    // Auto precharge closes the bank after its last beat; a paused clock holds it open
    if (burst_reg != SDC_IDLE && ap_reg && left_reg == 9'h001 && !col_cmd && cke_reg) begin
      open_next[bank_reg] = 1'b0;
    end
    // A one-beat burst ends on its own command, so the close comes with it
    if (col_cmd && addr_pins.addr[sdc_pkg::AP_BIT] && burst_len(bl_reg) == 9'h001) begin
      open_next[bank_sel] = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      open_reg <= '0;
      for (int b = 0; b < sdc_pkg::BANKS; b++) begin
        row_reg[b] <= '0;
      end
    end else begin
      open_reg <= open_next;
      row_reg <= row_next;
    end
  end

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  always_comb begin
    burst_next = burst_reg;
    bank_next = bank_reg;
    col_next = col_reg;
    left_next = left_reg;
    ap_next = ap_reg;
    wr_beat = 1'b0;
    rd_beat = 1'b0;
    beat_col = col_reg;
    beat_bank = bank_reg;
    // A new column command cuts the running burst, any cycle [R02]
    if (col_cmd) begin
      beat_col = addr_pins.addr[sdc_pkg::COL_W-1:0]; // [R22]
      beat_bank = bank_sel;
      burst_next = (cmd == sdc_pkg::CMD_WRITE) ? SDC_WRITE : SDC_READ;
      wr_beat = (cmd == sdc_pkg::CMD_WRITE); // [R10]
      rd_beat = (cmd == sdc_pkg::CMD_READ);
      bank_next = bank_sel;
      col_next = beat_col + 10'h001;
      left_next = burst_len(bl_reg) - 9'h001;
      ap_next = addr_pins.addr[sdc_pkg::AP_BIT];
      if (burst_len(bl_reg) == 9'h001) begin
        burst_next = SDC_IDLE;
      end
    end else if (stop_now || precharge_now || !cke_reg) begin
      // Stop ends at once; a paused clock simply holds the burst
      if (stop_now || precharge_now) begin
        burst_next = SDC_IDLE;
      end
    end else begin
      case (burst_reg)
        SDC_READ, SDC_WRITE: begin
          wr_beat = (burst_reg == SDC_WRITE);
          rd_beat = (burst_reg == SDC_READ);
          col_next = col_reg + 10'h001;
          left_next = left_reg - 9'h001;
          if (left_reg == 9'h001) begin
            burst_next = SDC_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
    beat_idx = mem_index(beat_bank, beat_col);
    rd_word.valid = rd_beat;
    rd_word.data = mem[beat_idx];
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      burst_reg <= SDC_IDLE;
      bank_reg <= '0;
      col_reg <= '0;
      left_reg <= '0;
      ap_reg <= 1'b0;
    end else begin
      burst_reg <= burst_next;
      bank_reg <= bank_next;
      col_reg <= col_next;
      left_reg <= left_next;
      ap_reg <= ap_next;
    end
  end

  // ----------------------------------------------------------------
  // Write storage
  // ----------------------------------------------------------------
  // Small window of storage; the mask drops the same-cycle word [R08]
  always_ff @(posedge mclk) begin
    if (wr_beat && !byte_mask) begin
      mem[beat_idx] <= dq_in;
    end
  end

  // ----------------------------------------------------------------
  // Read output
  // ----------------------------------------------------------------
  sdc_read_pipe u_read_pipe (
    .mclk(mclk),
    .rst_n(rst_n),
    .cas_latency(cl_reg),
    .word_in(rd_word),
    .kill(precharge_now || stop_now), // [R12]
    .mask_in(byte_mask), // [R09]
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  assign self_refresh = sref_reg;
  assign power_down = !cke_reg && !sref_reg;
  assign bank_open = open_reg;

endmodule // sdc_core
`default_nettype wire

// *** test/sdc_core_monitor.sv ***
// Checker for the SDRAM command timing core, watching its ports only.
// Assumes one clock, mclk, and the synchronous active-low rst_n.
`timescale 1ns/100ps
`default_nettype none
module sdc_core_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Command pins
  input wire logic clock_enable,
  input wire sdc_pkg::sdc_cmd_pins_t cmd_pins,
  input wire sdc_pkg::sdc_addr_t addr_pins,
  input wire logic byte_mask,
  // Data and status
  input wire logic [sdc_pkg::DQ_W-1:0] dq_in,
  input wire logic [sdc_pkg::DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic self_refresh,
  input wire logic power_down,
  input wire logic [sdc_pkg::BANKS-1:0] bank_open
);
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  logic [3:0] cmd;
  logic [1:0] ba;
  logic go;
  logic [1:0] cl_reg;
  logic [1:0] cl_next;
  assign cmd = cmd_pins;
  assign ba = {addr_pins.bank_select_bit1, addr_pins.bank_select_bit0};
  // Outputs are registered, so power_down stands in for the sampled enable
  assign go = !power_down && !self_refresh && !cmd_pins.chip_select_n;
  always_comb begin
    cl_next = cl_reg;
    if (go && cmd == sdc_pkg::CMD_MODE_LOAD && addr_pins.addr[5:4] != 2'h0) begin
      cl_next = addr_pins.addr[5:4];
    end
  end
  always_ff @(posedge mclk) begin
    cl_reg <= rst_n ? cl_next : sdc_pkg::CL_RESET;
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_cke_sleep:
  assert property (!clock_enable && !self_refresh && cmd != sdc_pkg::CMD_REFRESH |=> power_down)
    else $error("power down not entered");
  a_cke_wakes:
  assert property (clock_enable |=> !power_down && !self_refresh)
    else $error("clock enable did not resume");
  a_self_ref_entry:
  assert property (!power_down && !self_refresh && !clock_enable && cmd == sdc_pkg::CMD_REFRESH
    |=> self_refresh && !power_down) else $error("self refresh not entered");
  a_act_opens:
  assert property (go && cmd == sdc_pkg::CMD_ACTIVE |=> bank_open[$past(ba)])
    else $error("activate did not open bank");
  a_pre_all_closes:
  assert property (go && cmd == sdc_pkg::CMD_PRECHARGE && addr_pins.addr[10] |=> bank_open == 4'h0)
    else $error("precharge all left a bank open");
  a_mask_floats:
  assert property ((byte_mask && !power_down && clock_enable) ##1 clock_enable |-> ##2 !dq_oe)
    else $error("masked read beat driven");
  a_pre_hiz_cl3:
  assert property (go && cmd == sdc_pkg::CMD_PRECHARGE && cl_reg == 2'h3 |-> ##4 !dq_oe)
    else $error("outputs not floated after precharge");
  a_read_latency:
  assert property ((go && cmd == sdc_pkg::CMD_READ && cl_reg == 2'h2 && !byte_mask && clock_enable)
    ##1 (clock_enable && cmd == sdc_pkg::CMD_NOP) |=> ##1 dq_oe) else $error("read data late");
  c_read: cover property (go && cmd == sdc_pkg::CMD_READ);
  c_self_ref: cover property (self_refresh);
  c_precharge: cover property (go && cmd == sdc_pkg::CMD_PRECHARGE);
endmodule // sdc_core_monitor
bind sdc_core sdc_core_monitor i_sdc_core_monitor (.mclk, .rst_n, .clock_enable, .cmd_pins,
  .addr_pins, .byte_mask, .dq_in, .dq_out, .dq_oe, .self_refresh, .power_down, .bank_open);
`default_nettype wire

// *** test/sdc_ctrl_model.sv ***
// Memory controller model driving the core's command, mask and data pins.
// Assumes callers time everything; drives only at falling clock edges.
`timescale 1ns/100ps
`default_nettype none
module sdc_ctrl_model (
  // Clock
  input wire logic mclk,
  // Command side
  output var logic clock_enable,
  output var sdc_pkg::sdc_cmd_pins_t cmd_pins,
  output var sdc_pkg::sdc_addr_t addr_pins,
  output var logic byte_mask,
  output var logic [sdc_pkg::DQ_W-1:0] dq_in
);
  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  initial begin
    clock_enable = 1'h0;
    cmd_pins = sdc_pkg::sdc_cmd_pins_t'(sdc_pkg::CMD_NOP);
    addr_pins = '0;
    byte_mask = 1'h0;
    dq_in = 8'h00;
  end
  task automatic cmd(input sdc_pkg::sdc_cmd_t c, input logic [1:0] ba, input logic [11:0] a,
      input logic m, input logic [7:0] d, input logic ce);
    @(negedge mclk);
    clock_enable = ce;
    cmd_pins = sdc_pkg::sdc_cmd_pins_t'(c);
    addr_pins = sdc_pkg::sdc_addr_t'({ba, a});
    byte_mask = m;
    // Idle data toggles so a stale word can never pass for written data
    dq_in = (c == sdc_pkg::CMD_WRITE) ? d : ~dq_in;
  endtask
  task automatic nop(input int n);
    repeat (n) cmd(sdc_pkg::CMD_NOP, 2'h0, 12'h000, 1'h0, 8'h00, 1'h1);
  endtask
  task automatic power_up();
    nop(10000);
    repeat (2) begin
      cmd(sdc_pkg::CMD_REFRESH, 2'h0, 12'h000, 1'h0, 8'h00, 1'h1);
      nop(7);
    end
  endtask
endmodule // sdc_ctrl_model
`default_nettype wire

// *** test/sdc_core_tb.sv ***
// Self-checking bench for the SDRAM command timing core.
// Assumes the controller model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module sdc_core_tb;
  // ------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------
  logic mclk;
  logic rst_n;
  logic clock_enable;
  sdc_pkg::sdc_cmd_pins_t cmd_pins;
  sdc_pkg::sdc_addr_t addr_pins;
  logic byte_mask;
  logic [7:0] dq_in;
  logic [7:0] dq_out;
  logic dq_oe;
  logic self_refresh;
  logic power_down;
  logic [3:0] bank_open;
  int errors = 0;
  int check_count = 0;
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  sdc_ctrl_model i_sdc_ctrl_model (.mclk, .clock_enable, .cmd_pins, .addr_pins, .byte_mask,
    .dq_in);
  sdc_core i_sdc_core (.mclk, .rst_n, .clock_enable, .cmd_pins, .addr_pins, .byte_mask, .dq_in,
    .dq_out, .dq_oe, .self_refresh, .power_down, .bank_open);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input sdc_pkg::sdc_cmd_t c, input logic [1:0] ba, input logic [11:0] a,
      input logic m, input logic [7:0] d);
    i_sdc_ctrl_model.cmd(c, ba, a, m, d, 1'h1);
  endtask
  task automatic idle(input int n);
    i_sdc_ctrl_model.nop(n);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_cke();
    chk(8'(power_down), 8'h01);
    idle(2);
    chk(8'(power_down), 8'h00);
    repeat (2) i_sdc_ctrl_model.cmd(sdc_pkg::CMD_NOP, 2'h0, 12'h000, 1'h0, 8'h00, 1'h0);
    chk(8'(power_down), 8'h01);
    idle(2);
    chk(8'(power_down), 8'h00);
    $display("t_cke done");
  endtask
  task automatic t_wr_rd();
    send(sdc_pkg::CMD_ACTIVE, 2'h1, 12'h123, 1'h0, 8'h00);
    send(sdc_pkg::CMD_ACTIVE, 2'h2, 12'hABC, 1'h0, 8'h00);
    idle(3);
    chk(8'(bank_open), 8'h06);
    send(sdc_pkg::CMD_WRITE, 2'h1, 12'h002, 1'h0, 8'hA5);
    send(sdc_pkg::CMD_WRITE, 2'h1, 12'h003, 1'h0, 8'h5A);
    send(sdc_pkg::CMD_WRITE, 2'h1, 12'h003, 1'h1, 8'hC3);
    send(sdc_pkg::CMD_WRITE, 2'h2, 12'h000, 1'h0, 8'h96);
    idle(1);
    send(sdc_pkg::CMD_READ, 2'h1, 12'h002, 1'h0, 8'h00);
    send(sdc_pkg::CMD_READ, 2'h1, 12'h003, 1'h0, 8'h00);
    send(sdc_pkg::CMD_READ, 2'h2, 12'h000, 1'h0, 8'h00);
    idle(1);
    chk(dq_out, 8'hA5);
    idle(1);
    chk(dq_out, 8'h5A);
    idle(1);
    chk(dq_out, 8'h96);
    send(sdc_pkg::CMD_READ, 2'h1, 12'h002, 1'h1, 8'h00);
    idle(3);
    chk(8'(dq_oe), 8'h00);
    $display("t_wr_rd done");
  endtask
  task automatic t_cl3_pre();
    send(sdc_pkg::CMD_PRECHARGE, 2'h0, 12'h400, 1'h0, 8'h00);
    idle(2);
    chk(8'(bank_open), 8'h00);
    send(sdc_pkg::CMD_MODE_LOAD, 2'h0, 12'h033, 1'h0, 8'h00);
    idle(2);
    send(sdc_pkg::CMD_ACTIVE, 2'h0, 12'h000, 1'h0, 8'h00);
    idle(2);
    send(sdc_pkg::CMD_READ, 2'h0, 12'h000, 1'h0, 8'h00);
    idle(1);
    send(sdc_pkg::CMD_PRECHARGE, 2'h0, 12'h400, 1'h0, 8'h00);
    idle(2);
    chk(8'(dq_oe), 8'h01);
    idle(1);
    chk(8'(dq_oe), 8'h01);
    idle(1);
    chk(8'(dq_oe), 8'h00);
    send(sdc_pkg::CMD_MODE_LOAD, 2'h0, 12'h020, 1'h0, 8'h00);
    idle(2);
    $display("t_cl3_pre done");
  endtask
  task automatic t_self_ref();
    send(sdc_pkg::CMD_REFRESH, 2'h0, 12'h000, 1'h0, 8'h00);
    idle(7);
    chk(8'(self_refresh), 8'h00);
    i_sdc_ctrl_model.cmd(sdc_pkg::CMD_REFRESH, 2'h0, 12'h000, 1'h0, 8'h00, 1'h0);
    i_sdc_ctrl_model.cmd(sdc_pkg::CMD_NOP, 2'h0, 12'h000, 1'h0, 8'h00, 1'h0);
    chk({7'h00, self_refresh} | {6'h00, power_down, 1'h0}, 8'h01);
    idle(2);
    chk(8'(self_refresh), 8'h00);
    idle(7);
    $display("t_self_ref done");
  endtask
  task automatic t_auto_pre();
    send(sdc_pkg::CMD_ACTIVE, 2'h3, 12'h055, 1'h0, 8'h00);
    idle(2);
    send(sdc_pkg::CMD_WRITE, 2'h3, 12'h401, 1'h0, 8'h3C);
    idle(1);
    chk(8'(bank_open), 8'h00);
    idle(sdc_pkg::WR_ACT_GAP);
    send(sdc_pkg::CMD_ACTIVE, 2'h3, 12'h055, 1'h0, 8'h00);
    idle(1);
    chk(8'(bank_open), 8'h08);
    send(sdc_pkg::CMD_READ, 2'h3, 12'h001, 1'h0, 8'h00);
    idle(3);
    chk(dq_out, 8'h3C);
    send(sdc_pkg::CMD_PRECHARGE, 2'h3, 12'h000, 1'h0, 8'h00);
    idle(1);
    chk(8'(bank_open), 8'h00);
    $display("t_auto_pre done");
  endtask
  // Watchdog sized well past the power-up pause plus all scenarios
  initial begin
    #200000;
    errors++;
    test_done();
  end
  initial begin
    rst_n = 1'h0;
    repeat (20) @(negedge mclk);
    rst_n = 1'h1;
    t_cke();
    i_sdc_ctrl_model.power_up();
    t_wr_rd();
    t_cl3_pre();
    t_auto_pre();
    t_self_ref();
    test_done();
  end
endmodule // sdc_core_tb
`default_nettype wire
